// ### hdl/rcf_defs.svh
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH

// Register byte addresses
`define RCF_ADDR_FLAGS 4'h0
`define RCF_ADDR_IRQ_STAT 4'h4
`define RCF_ADDR_IRQ_CLR 4'h8
`define RCF_ADDR_IRQ_EN 4'hC

// Flag positions
`define RCF_BIT_STACK_OVER 7
`define RCF_BIT_STACK_UNDER 6
`define RCF_BIT_EXTPIN 3
`define RCF_BIT_OPCODE 2
`define RCF_BIT_PWRON 1
`define RCF_BIT_BROWN 0

// Writable mask: bits 5-4 are unimplemented
`define RCF_WR_MASK 8'hCF

// Reset values
`define RCF_FLAGS_COLD 8'h0C
`define RCF_IRQ_EN_RST 4'h0

// Interrupt status positions
`define RCF_IRQ_STACK_OVER 0
`define RCF_IRQ_STACK_UNDER 1
`define RCF_IRQ_EXTPIN 2
`define RCF_IRQ_OPCODE 3

`endif

// ### hdl/rcf_pkg.sv
package rcf_pkg;

    typedef struct packed {
        logic [3:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } rcf_wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } rcf_wb_rsp_t;

    typedef struct packed {
        logic powerOn;
        logic brownOut;
        logic extPin;
        logic resetOpcode;
        logic stackOver;
        logic stackUnder;
    } rcf_events_t;

endpackage

// ### hdl/rcf_reset_cause.sv
// Operation
// - Stack overflow sets bit 7, which stays set until firmware writes zero.
// - Stack underflow sets bit 6, which stays set until firmware writes zero.
// - Bits 5 and 4 always read zero and ignore writes.
// - An external pin reset clears bit 3; firmware writes one to rearm it.
// - A reset instruction clears bit 2; firmware writes one to rearm it.
// - Bit 1 reads zero after power-on reset; software then writes one.
// - Bit 0 reads zero after brown-out or power-on reset; software then writes one.
// - Cold resets load zero in the stack flags and one in the pin and opcode flags.
// - Other resets leave the power-on and brown-out flags unchanged.
// - Stack events request a reset only when the stack reset enable is set.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`include "rcf_defs.svh"

module rcf_reset_cause
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Wishbone slave
    input rcf_pkg::rcf_wb_req_t wbReq,
    output rcf_pkg::rcf_wb_rsp_t wbRsp,
    // Reset cause events, one-cycle pulses
    input rcf_pkg::rcf_events_t evt,
    // Configuration
    input wire logic stack_reset_enable,
    // Outputs
    output logic stackResetReq,
    output logic [7:0] reset_cause_flags,
    output logic irq
);
    import rcf_pkg::*;

    // Bus decode
    logic access;
    logic wrByte0;
    logic wrFlags;
    logic wrClr;
    logic wrEn;
    logic [7:0] wrData;

    // Event decode
    logic coldEvt;
    logic stackEvt;

    // Flag register, one flip-flop per implemented bit
    logic stackOver_r;
    logic stackOver_nxt;
    logic stackUnder_r;
    logic stackUnder_nxt;
    logic extPin_r;
    logic extPin_nxt;
    logic opcode_r;
    logic opcode_nxt;
    logic powerOn_r;
    logic powerOn_nxt;
    logic brownOut_r;
    logic brownOut_nxt;
    logic [7:0] flags;

    // Interrupt status and enable
    logic [3:0] irqSet;
    logic [3:0] irqClr;
    logic [3:0] irqStat_r;
    logic [3:0] irqStat_nxt;
    logic [3:0] irqEn_r;
    logic [3:0] irqEn_nxt;
    genvar gi;

    // Bus response
    logic ack_r;
    logic [31:0] rdData_r;
    logic [31:0] rdData_nxt;

    // Image loaded by power-on and the asynchronous reset; brown-out loads all of it but bit 1
    localparam logic [7:0] coldImage = `RCF_FLAGS_COLD;

    // Request ends once acked; a strobe still high in the ack cycle is not taken twice
    assign access = wbReq.cyc && wbReq.stb && !ack_r;
    assign wrByte0 = access && wbReq.we && wbReq.sel[0];
    assign wrFlags = wrByte0 && (wbReq.adr == `RCF_ADDR_FLAGS);
    assign wrClr = wrByte0 && (wbReq.adr == `RCF_ADDR_IRQ_CLR);
    assign wrEn = wrByte0 && (wbReq.adr == `RCF_ADDR_IRQ_EN);
    assign wrData = wbReq.dat[7:0];

    // Power-on reloads the image, brown-out all but bit 1; either outranks every warm flag event in the same cycle
    assign coldEvt = evt.powerOn || evt.brownOut;
    assign stackEvt = evt.stackOver || evt.stackUnder;

    // Overflow flag, hardware event applied after the write so it wins
    always_comb
    begin
        stackOver_nxt = stackOver_r;
        if (wrFlags)
        begin
            stackOver_nxt = wrData[`RCF_BIT_STACK_OVER];
        end
        if (coldEvt)
        begin
            stackOver_nxt = 1'h0;
        end
        else if (evt.stackOver)
        begin
            stackOver_nxt = 1'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stackOver_r <= coldImage[`RCF_BIT_STACK_OVER];
        end
        else
        begin
            stackOver_r <= stackOver_nxt;
        end
    end

    // Underflow flag
    always_comb
    begin
        stackUnder_nxt = stackUnder_r;
        if (wrFlags)
        begin
            stackUnder_nxt = wrData[`RCF_BIT_STACK_UNDER];
        end
        if (coldEvt)
        begin
            stackUnder_nxt = 1'h0;
        end
        else if (evt.stackUnder)
        begin
            stackUnder_nxt = 1'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stackUnder_r <= coldImage[`RCF_BIT_STACK_UNDER];
        end
        else
        begin
            stackUnder_r <= stackUnder_nxt;
        end
    end

    // External pin flag, active low
    always_comb
    begin
        extPin_nxt = extPin_r;
        if (wrFlags)
        begin
            extPin_nxt = wrData[`RCF_BIT_EXTPIN];
        end
        if (coldEvt)
        begin
            extPin_nxt = 1'h1;
        end
        else if (evt.extPin)
        begin
            extPin_nxt = 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            extPin_r <= coldImage[`RCF_BIT_EXTPIN];
        end
        else
        begin
            extPin_r <= extPin_nxt;
        end
    end

    // Reset instruction flag, active low
    always_comb
    begin
        opcode_nxt = opcode_r;
        if (wrFlags)
        begin
            opcode_nxt = wrData[`RCF_BIT_OPCODE];
        end
        if (coldEvt)
        begin
            opcode_nxt = 1'h1;
        end
        else if (evt.resetOpcode)
        begin
            opcode_nxt = 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opcode_r <= coldImage[`RCF_BIT_OPCODE];
        end
        else
        begin
            opcode_r <= opcode_nxt;
        end
    end

    // Power-on flag; a brown-out leaves it alone so the two causes stay apart
    always_comb
    begin
        powerOn_nxt = powerOn_r;
        if (wrFlags)
        begin
            powerOn_nxt = wrData[`RCF_BIT_PWRON];
        end
        if (evt.powerOn)
        begin
            powerOn_nxt = 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            powerOn_r <= coldImage[`RCF_BIT_PWRON];
        end
        else
        begin
            powerOn_r <= powerOn_nxt;
        end
    end

    // Brown-out flag, cleared by either cold cause
    always_comb
    begin
        brownOut_nxt = brownOut_r;
        if (wrFlags)
        begin
            brownOut_nxt = wrData[`RCF_BIT_BROWN];
        end
        if (coldEvt)
        begin
            brownOut_nxt = 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            brownOut_r <= coldImage[`RCF_BIT_BROWN];
        end
        else
        begin
            brownOut_r <= brownOut_nxt;
        end
    end

    // Unimplemented positions are tied to zero, so writes to them vanish
    assign flags = {stackOver_r, stackUnder_r, 2'h0, extPin_r, opcode_r, powerOn_r, brownOut_r};

    // Stack events only force a reset when enabled; the flag records regardless
    assign stackResetReq = stack_reset_enable && stackEvt;

    // Status positions follow the interrupt map
    assign irqSet[`RCF_IRQ_STACK_OVER] = evt.stackOver;
    assign irqSet[`RCF_IRQ_STACK_UNDER] = evt.stackUnder;
    assign irqSet[`RCF_IRQ_EXTPIN] = evt.extPin;
    assign irqSet[`RCF_IRQ_OPCODE] = evt.resetOpcode;
    assign irqClr = wrClr ? wbReq.dat[3:0] : 4'h0;

    // Per-bit sticky status; an event in the clear cycle wins so none is lost
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_irq_bit
            assign irqStat_nxt[gi] = irqSet[gi] || (irqStat_r[gi] && !irqClr[gi]);
        end
    endgenerate

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqStat_r <= 4'h0;
        end
        else
        begin
            irqStat_r <= irqStat_nxt;
        end
    end

    assign irqEn_nxt = wrEn ? wbReq.dat[3:0] : irqEn_r;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqEn_r <= `RCF_IRQ_EN_RST;
        end
        else
        begin
            irqEn_r <= irqEn_nxt;
        end
    end

    // Level output, no latency beyond the status and enable flip-flops
    assign irq = |(irqStat_r & irqEn_r);

    // Read mux; unmapped addresses read zero and are still acked
    always_comb
    begin
        rdData_nxt = 32'h0000_0000;
        case (wbReq.adr)
            `RCF_ADDR_FLAGS: rdData_nxt = {24'h00_0000, flags};
            `RCF_ADDR_IRQ_STAT: rdData_nxt = {28'h000_0000, irqStat_r};
            `RCF_ADDR_IRQ_EN: rdData_nxt = {28'h000_0000, irqEn_r};
            default: rdData_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_r <= 1'h0;
        end
        else
        begin
            ack_r <= access;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdData_r <= 32'h0000_0000;
        end
        else
        begin
            rdData_r <= rdData_nxt;
        end
    end

    assign wbRsp.ack = ack_r;
    assign wbRsp.dat = rdData_r;
    assign reset_cause_flags = flags;

endmodule

// ### sim/rcf_checker.sv
module rcf_checker
(
    // Clock
    input wire logic core_clk,
    input wire logic arst_n,
    // Watched
    input rcf_pkg::rcf_wb_req_t wbReq,
    input rcf_pkg::rcf_wb_rsp_t wbRsp,
    input rcf_pkg::rcf_events_t evt,
    input wire logic stack_reset_enable,
    input wire logic stackResetReq,
    input wire logic [7:0] reset_cause_flags
);
    import rcf_pkg::*;
    logic c;
    logic w;
    logic [7:0] f;
    // Cold events and taken flag writes may move any flag
    assign c = evt.powerOn || evt.brownOut;
    assign w = wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack && wbReq.sel[0] && wbReq.adr == 4'h0;
    assign f = reset_cause_flags;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    ovf_set_a: assert property (evt.stackOver && !c |=> f[7]) else $error("overflow");
    unused_zero_a: assert property (f[5:4] == 2'h0) else $error("unused bits");
    pin_clr_a: assert property (evt.extPin && !c |=> !f[3]) else $error("pin");
    opc_clr_a: assert property (evt.resetOpcode && !c |=> !f[2]) else $error("opcode");
    por_load_a: assert property (evt.powerOn |=> f == 8'h0C) else $error("power-on");
    bor_load_a: assert property (evt.brownOut |=> (f & 8'hCD) == 8'h0C) else $error("brown-out");
    warm_keep_a: assert property (!c && !w |=> f[1:0] == $past(f[1:0])) else $error("warm");
    stk_req_a: assert property (stackResetReq == (stack_reset_enable && (evt.stackOver || evt.stackUnder)))
        else $error("stack request");
    cover property (c);
    cover property (w);
    cover property (stackResetReq);
endmodule
bind rcf_reset_cause rcf_checker u_chk (.*);

// ### sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rcf_pkg::*;
    logic core_clk = 0, arst_n = 0, ena = 1, irq, req;
    logic [7:0] f;
    rcf_wb_req_t wbReq = '0;
    rcf_wb_rsp_t wbRsp;
    rcf_events_t evt = '0;
    int n_errors = 0, n_tests = 0;
    // Cold-event steps write the enable register so no read races the update
    logic [25:0] tbl [6] = '{{4'h0, 8'hFF, 6'h00, 8'hCF}, {4'h0, 8'h0F, 6'h02, 8'h8F}, {4'h0, 8'h0F, 6'h01, 8'h4F},
        {4'h0, 8'hCF, 6'h0C, 8'hC3}, {4'hC, 8'h00, 6'h10, 8'h0E}, {4'hC, 8'h00, 6'h20, 8'h0C}};
    always #10 core_clk = ~core_clk;
    rcf_reset_cause DUT (.core_clk(core_clk), .arst_n(arst_n), .wbReq(wbReq), .wbRsp(wbRsp), .evt(evt),
        .stack_reset_enable(ena), .stackResetReq(req), .reset_cause_flags(f), .irq(irq));
    task automatic chk(string s, logic [7:0] x, logic [7:0] g);
        n_tests++;
        if (g !== x)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic acc(logic [3:0] a, logic w, logic [7:0] d, logic [5:0] e);
        wbReq <= '{a, {24'h0, d}, 4'hF, w, 1'b1, 1'b1};
        evt <= e;
        @(posedge core_clk);
        evt <= '0;
        chk("stack req", {7'h0, ena && (e[1] || e[0])}, {7'h0, req});
        while (wbRsp.ack !== 1'h1) @(posedge core_clk);
        if (!w) chk("rdata", d, wbRsp.dat[7:0]);
        wbReq <= '0;
        @(posedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #20000 n_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1;
        @(posedge core_clk);
        acc(4'h0, 0, 8'h0C, 6'h00);
        foreach (tbl[i])
        begin
            ena <= !i[1];
            acc(tbl[i][25:22], 1, tbl[i][21:14], tbl[i][13:8]);
            acc(4'h0, 0, tbl[i][7:0], 6'h00);
        end
        acc(4'h2, 0, 8'h00, 6'h00);
        $display("flags test done");
        chk("irq", 8'h00, {7'h0, irq});
        acc(4'hC, 1, 8'h01, 6'h00);
        chk("irq", 8'h01, {7'h0, irq});
        acc(4'h8, 1, 8'h0F, 6'h00);
        chk("irq", 8'h00, {7'h0, irq});
        acc(4'h4, 0, 8'h00, 6'h00);
        $display("irq test done");
        report_and_stop();
    end
endmodule
